// >>> eag_top.sv
/*
 Effective address generator: resolves register, immediate and memory
 operands, sizes, segment choice and real mode linear address.
 Assumes an APB master in the CLK domain feeds instruction fields.
*/
// Contract
// RL1: Register mode reads one general register at 8, 16 or 32 bits.
// RL2: Immediate mode takes the operand from the instruction bytes.
// RL3: Memory address adds any subset of base, scaled index, displacement.
// RL4: Seven memory combinations are served; an empty one is flagged.
// RL5: 32-bit addressing scales the index by 1, 2, 4 or 8.
// RL6: 32-bit base is any register; index is any but the stack pointer.
// RL7: 32-bit displacement is absent, 8 bits or 32 bits.
// RL8: 16-bit form allows limited base and index, no scale, 16-bit disp.
// RL9: Only base plus index together costs one extra clock.
// RL10: Default sizes follow the code segment size bit: 0 16, 1 32.
// RL11: Real mode defaults both sizes to 16 bits.
// RL12: Each size prefix inverts its default for one instruction.
// RL13: Real mode offset above 0FFFFH raises a protection fault.
// RL14: Fetches use code segment; pushes use stack segment, no override.
// RL15: Pops and returns always use the stack segment.
// RL16: String destination always uses the extra segment.
// RL17: Other data defaults by base register; an override may replace it.
// RL18: Signed values are two's complement at every width.
// RL19: Real mode linear address is selector shifted four plus offset.
// RL20: The effective address is cut to the active address size.
`timescale 1ns/1ns
`include "eag_consts.svh"

module eag_top #(
    parameter int APB_AW  = 8,
    parameter int NUM_GPR = 8,
    parameter int NUM_SEG = 6
) (
    // Clock and reset
    input  wire logic              CLK,
    input  wire logic              RST,
    // APB slave
    input  wire logic              PSEL,
    input  wire logic              PENABLE,
    input  wire logic              PWRITE,
    input  wire logic [APB_AW-1:0] PADDR,
    input  wire logic [31:0]       PWDATA,
    output logic      [31:0]       PRDATA,
    output logic                   PREADY,
    output logic                   PSLVERR,
    // Result to segmentation unit
    output logic      [31:0]       OFFSET,
    output logic      [31:0]       LINEAR,
    output logic      [31:0]       OPERAND,
    output logic      [2:0]        SEG_SEL,
    output logic                   GP_FAULT,
    output logic                   FORM_ERR,
    output logic                   OP_SIZE32,
    output logic                   ADDR_SIZE32,
    output logic                   RES_VALID
);
    import eag_pkg::*;

    // --------------------------------------------------------------
    // Elaboration checks
    // --------------------------------------------------------------
    generate
        if (APB_AW < 8) begin : g_bad_aw
            $error("APB address must be at least 8 bits");
        end
        if (NUM_GPR != 8) begin : g_bad_gpr
            $error("Exactly eight general registers are decoded");
        end
        if (NUM_SEG != 6) begin : g_bad_seg
            $error("Exactly six segment registers are decoded");
        end
    endgenerate

    // --------------------------------------------------------------
    // State
    // --------------------------------------------------------------
    logic [1:0]        cfg_reg;
    eag_insn_t         insn_reg;
    logic [31:0]       disp_reg;
    logic [31:0]       gpr_reg [NUM_GPR];
    logic [15:0]       seg_reg [NUM_SEG];
    eag_state_t        state_reg;
    eag_state_t        state_next;
    logic [31:0]       part_reg;
    eag_result_t       res_reg;
    eag_result_t       res_next;
    logic              done_reg;
    logic              valid_reg;
    logic [31:0]       prdata_reg;
    logic              pready_reg;
    logic              pslverr_reg;

    // --------------------------------------------------------------
    // APB decode
    // --------------------------------------------------------------
    logic [7:0]        addr;
    logic              acc_phase;
    logic              wr_fire;
    logic              busy;
    logic              hit_cfg;
    logic              hit_insn;
    logic              hit_disp;
    logic              hit_ro;
    logic              hit_gpr;
    logic              hit_seg;
    logic              mapped;
    logic              refuse;
    logic [2:0]        win_idx;
    logic              start;

    assign addr      = PADDR[7:0];
    assign acc_phase = PSEL & PENABLE & ~pready_reg;
    assign wr_fire   = PSEL & PENABLE & pready_reg & PWRITE & ~pslverr_reg;
    assign busy      = (state_reg != EAG_ST_IDLE);
    assign win_idx   = addr[4:2];
    assign hit_cfg   = (addr == `EAG_OFF_CFG);
    assign hit_insn  = (addr == `EAG_OFF_INSN);
    assign hit_disp  = (addr == `EAG_OFF_DISP);
    assign hit_ro    = (addr == `EAG_OFF_RESULT) |
                       (addr == `EAG_OFF_LINEAR) |
                       (addr == `EAG_OFF_STATUS) |
                       (addr == `EAG_OFF_OPERAND);
    assign hit_gpr   = (addr[7:5] == `EAG_WIN_GPR) & (addr[1:0] == 2'h0);
    assign hit_seg   = (addr[7:5] == `EAG_WIN_SEG) & (addr[1:0] == 2'h0) &
                       (win_idx <= `EAG_SEG_LAST);
    assign mapped    = hit_cfg | hit_insn | hit_disp | hit_ro |
                       hit_gpr | hit_seg;
    assign refuse    = ~mapped | (PWRITE & busy);
    assign start     = wr_fire & hit_insn;

    // --------------------------------------------------------------
    // Sizes
    // --------------------------------------------------------------
    logic              real_mode;
    logic              def32;
    logic              op32;
    logic              addr32;

    assign real_mode = cfg_reg[`EAG_CFG_REAL];
    assign def32     = ~real_mode & cfg_reg[`EAG_CFG_DBIT]; // [RL10] [RL11]
    assign op32      = def32 ^ insn_reg.op_pfx;             // [RL12]
    assign addr32    = def32 ^ insn_reg.ad_pfx;             // [RL12]

    // --------------------------------------------------------------
    // Address terms
    // --------------------------------------------------------------
    logic [NUM_GPR*32-1:0] gpr_flat;
    logic [31:0]       base_term;
    logic [31:0]       idx_val;
    logic [31:0]       idx_term;
    logic [31:0]       disp_ext;
    logic [31:0]       part_sum;
    logic [31:0]       sum_src;
    logic [31:0]       ea_full;
    logic [31:0]       offset;
    logic              two_part;
    logic              is_mem;

    genvar gi;
    generate
        for (gi = 0; gi < NUM_GPR; gi++) begin : g_flat
            assign gpr_flat[gi*32 +: 32] = gpr_reg[gi];
        end
    endgenerate

    assign is_mem    = (insn_reg.mode == EAG_MODE_MEM);
    assign base_term = insn_reg.base_en ? gpr_reg[insn_reg.base_sel]
                                        : `EAG_WORD_RST;          // [RL3]
    assign idx_val   = gpr_reg[insn_reg.idx_sel];
    assign idx_term  = !insn_reg.idx_en ? `EAG_WORD_RST :
                       addr32 ? idx_val << insn_reg.scale         // [RL5]
                              : idx_val;                          // [RL8]
    assign disp_ext  =
        (insn_reg.disp_sz == `EAG_DISP_8)    ?
            {{24{disp_reg[7]}}, disp_reg[7:0]} :                  // [RL18]
        (insn_reg.disp_sz == `EAG_DISP_FULL) ?
            (addr32 ? disp_reg                                    // [RL7]
                    : {{16{disp_reg[15]}}, disp_reg[15:0]}) :     // [RL8]
            `EAG_WORD_RST;
    assign two_part  = insn_reg.base_en & insn_reg.idx_en;
    assign part_sum  = base_term + idx_term;                      // [RL3]
    assign sum_src   = (state_reg == EAG_ST_EXTRA) ? part_reg : part_sum;
    assign ea_full   = sum_src + disp_ext;                        // [RL3]
    assign offset    = addr32 ? ea_full
                              : {16'h0, ea_full[15:0]};           // [RL20]

    // --------------------------------------------------------------
    // Form checks
    // --------------------------------------------------------------
    logic              bad16;
    logic              bad32;
    logic              empty_mem;
    logic              bad_disp;
    logic              bad_kind;
    logic              bad_form;

    assign bad16     = ~addr32 & (
        (insn_reg.base_en & (insn_reg.base_sel != `EAG_GPR_BASE) &
                            (insn_reg.base_sel != `EAG_GPR_FP)) |
        (insn_reg.idx_en  & (insn_reg.idx_sel  != `EAG_GPR_SI) &
                            (insn_reg.idx_sel  != `EAG_GPR_DI)));  // [RL8]
    assign bad32     = addr32 & insn_reg.idx_en &
                       (insn_reg.idx_sel == `EAG_GPR_SP);          // [RL6]
    assign empty_mem = ~insn_reg.base_en & ~insn_reg.idx_en &
                       (insn_reg.disp_sz == `EAG_DISP_NONE);       // [RL4]
    assign bad_disp  = (insn_reg.disp_sz > `EAG_DISP_FULL);        // [RL7]
    assign bad_form  = (insn_reg.mode == EAG_MODE_BAD) |
                       (is_mem & (bad16 | bad32 | empty_mem |
                                  bad_disp | bad_kind));           // [RL4]

    // --------------------------------------------------------------
    // Segment choice and operand value
    // --------------------------------------------------------------
    logic [2:0]        seg_pick;
    logic [31:0]       reg_val;
    logic [31:0]       imm_val;
    logic [31:0]       seg_base;
    logic [31:0]       linear;
    logic              gp_fault;

    eag_seg_pick u_seg_pick (
        .kind     (insn_reg.kind),
        .ovr_en   (insn_reg.ovr_en),
        .ovr_seg  (insn_reg.ovr_seg),
        .base_en  (insn_reg.base_en),
        .base_sel (insn_reg.base_sel),
        .seg      (seg_pick),
        .bad_kind (bad_kind)
    );

    eag_reg_read #(
        .NUM_GPR (NUM_GPR)
    ) u_reg_read (
        .gpr_flat (gpr_flat),
        .sel      (insn_reg.reg_sel),
        .wide     (insn_reg.wide),
        .op32     (op32),
        .value    (reg_val)                                        // [RL1]
    );

    assign imm_val  = !insn_reg.wide ? {24'h0, disp_reg[7:0]} :
                      op32 ? disp_reg : {16'h0, disp_reg[15:0]};   // [RL2]
    assign seg_base = 32'(seg_reg[seg_pick]) << `EAG_SEG_SHIFT;
    assign linear   = real_mode ? seg_base + offset : offset;      // [RL19]
    assign gp_fault = is_mem & real_mode &
                      (offset > `EAG_REAL_LIMIT);                  // [RL13]

    always_comb begin
        res_next          = res_reg;
        res_next.offset   = offset;
        res_next.linear   = linear;
        res_next.seg      = seg_pick;
        res_next.gp_fault = gp_fault & ~bad_form;
        res_next.bad_form = bad_form;
        res_next.op32     = op32;
        res_next.addr32   = addr32;
        unique case (insn_reg.mode)
            EAG_MODE_REG: res_next.operand = reg_val;              // [RL1]
            EAG_MODE_IMM: res_next.operand = imm_val;              // [RL2]
            default:      res_next.operand = offset;
        endcase
    end

    // --------------------------------------------------------------
    // Sequencer
    // --------------------------------------------------------------
    logic              finish;

    always_comb begin
        state_next = state_reg;
        unique case (state_reg)
            EAG_ST_IDLE:  if (start) state_next = EAG_ST_CALC;
            EAG_ST_CALC:  if (is_mem & two_part & ~bad_form) begin
                state_next = EAG_ST_EXTRA;                         // [RL9]
            end else begin
                state_next = EAG_ST_IDLE;
            end
            EAG_ST_EXTRA: state_next = EAG_ST_IDLE;
            default:      state_next = EAG_ST_IDLE;
        endcase
    end

    assign finish = busy & (state_next == EAG_ST_IDLE);

    always_ff @(posedge CLK) begin
        if (RST) begin
            state_reg <= EAG_ST_IDLE;
            part_reg  <= `EAG_WORD_RST;
        end else begin
            state_reg <= state_next;
            part_reg  <= part_sum;                                 // [RL9]
        end
    end

    always_ff @(posedge CLK) begin
        if (RST) begin
            res_reg   <= '0;
            done_reg  <= 1'b0;
            valid_reg <= 1'b0;
        end else begin
            valid_reg <= finish;
            if (finish) begin
                res_reg  <= res_next;
                done_reg <= 1'b1;
            end else if (start) begin
                done_reg <= 1'b0;
            end
        end
    end

    // --------------------------------------------------------------
    // Software registers
    // --------------------------------------------------------------
    always_ff @(posedge CLK) begin
        if (RST) begin
            cfg_reg  <= `EAG_CFG_RST;
            insn_reg <= '0;
            disp_reg <= `EAG_WORD_RST;
        end else if (wr_fire) begin
            if (hit_cfg) cfg_reg <= PWDATA[1:0];
            if (hit_insn) insn_reg <= eag_insn_t'(PWDATA);
            if (hit_disp) disp_reg <= PWDATA;
        end
    end

    generate
        for (gi = 0; gi < NUM_GPR; gi++) begin : g_gpr
            always_ff @(posedge CLK) begin
                if (RST) begin
                    gpr_reg[gi] <= `EAG_WORD_RST;
                end else if (wr_fire & hit_gpr & (win_idx == gi)) begin
                    gpr_reg[gi] <= PWDATA;
                end
            end
        end
        for (gi = 0; gi < NUM_SEG; gi++) begin : g_seg
            always_ff @(posedge CLK) begin
                if (RST) begin
                    seg_reg[gi] <= `EAG_SEL_RST;
                end else if (wr_fire & hit_seg & (win_idx == gi)) begin
                    seg_reg[gi] <= PWDATA[15:0];
                end
            end
        end
    endgenerate

    // --------------------------------------------------------------
    // Read data
    // --------------------------------------------------------------
    eag_status_t       status;
    logic [31:0]       rd_data;

    assign status.pad      = '0;
    assign status.busy     = busy;
    assign status.done     = done_reg;
    assign status.gp_fault = res_reg.gp_fault;
    assign status.bad_form = res_reg.bad_form;
    assign status.addr32   = res_reg.addr32;
    assign status.op32     = res_reg.op32;
    assign status.seg      = res_reg.seg;

    assign rd_data =
        hit_cfg                      ? {30'h0, cfg_reg}     :
        hit_insn                     ? 32'(insn_reg)        :
        hit_disp                     ? disp_reg             :
        (addr == `EAG_OFF_RESULT)    ? res_reg.offset       :
        (addr == `EAG_OFF_LINEAR)    ? res_reg.linear       :
        (addr == `EAG_OFF_STATUS)    ? 32'(status)          :
        (addr == `EAG_OFF_OPERAND)   ? res_reg.operand      :
        hit_gpr                      ? gpr_reg[win_idx]     :
        hit_seg                      ? {16'h0, seg_reg[win_idx]} :
                                       `EAG_WORD_RST;

    always_ff @(posedge CLK) begin
        if (RST) begin
            prdata_reg  <= `EAG_WORD_RST;
            pready_reg  <= 1'b0;
            pslverr_reg <= 1'b0;
        end else begin
            pready_reg  <= acc_phase;
            pslverr_reg <= acc_phase & refuse;
            if (acc_phase & ~PWRITE) prdata_reg <= rd_data;
        end
    end

    // --------------------------------------------------------------
    // Outputs
    // --------------------------------------------------------------
    assign PRDATA      = prdata_reg;
    assign PREADY      = pready_reg;
    assign PSLVERR     = pslverr_reg;
    assign OFFSET      = res_reg.offset;
    assign LINEAR      = res_reg.linear;
    assign OPERAND     = res_reg.operand;
    assign SEG_SEL     = res_reg.seg;
    assign GP_FAULT    = res_reg.gp_fault;
    assign FORM_ERR    = res_reg.bad_form;
    assign OP_SIZE32   = res_reg.op32;
    assign ADDR_SIZE32 = res_reg.addr32;
    assign RES_VALID   = valid_reg;

endmodule

// >>> eag_consts.svh
/*
 Named offsets, codes, field positions and reset values of the
 effective address generator.
 Assumes inclusion by bare name from every design file that needs it.
*/
`ifndef EAG_CONSTS_SVH
`define EAG_CONSTS_SVH

// --------------------------------------------------------------
// Register offsets (byte addresses on APB)
// --------------------------------------------------------------
`define EAG_OFF_CFG      8'h00
`define EAG_OFF_INSN     8'h04
`define EAG_OFF_DISP     8'h08
`define EAG_OFF_RESULT   8'h0C
`define EAG_OFF_LINEAR   8'h10
`define EAG_OFF_STATUS   8'h14
`define EAG_OFF_OPERAND  8'h18
`define EAG_WIN_GPR      3'h1
`define EAG_WIN_SEG      3'h2

// --------------------------------------------------------------
// Configuration bits and reset values
// --------------------------------------------------------------
`define EAG_CFG_REAL     0
`define EAG_CFG_DBIT     1
`define EAG_CFG_RST      2'h1
`define EAG_WORD_RST     32'h0000_0000
`define EAG_SEL_RST      16'h0000

// --------------------------------------------------------------
// General register codes
// --------------------------------------------------------------
`define EAG_GPR_BASE     3'h3
`define EAG_GPR_SP       3'h4
`define EAG_GPR_FP       3'h5
`define EAG_GPR_SI       3'h6
`define EAG_GPR_DI       3'h7

// --------------------------------------------------------------
// Segment register codes
// --------------------------------------------------------------
`define EAG_SEG_EXTRA    3'h0
`define EAG_SEG_CODE     3'h1
`define EAG_SEG_STACK    3'h2
`define EAG_SEG_DATA     3'h3
`define EAG_SEG_LAST     3'h5

// --------------------------------------------------------------
// Displacement sizes and limits
// --------------------------------------------------------------
`define EAG_DISP_NONE    2'h0
`define EAG_DISP_8       2'h1
`define EAG_DISP_FULL    2'h2
`define EAG_REAL_LIMIT   32'h0000_FFFF
`define EAG_SEG_SHIFT    4

`endif

// >>> eag_pkg.sv
/*
 Types of the effective address generator: modes, reference kinds,
 states and the packed carriers of instruction, status and result.
 Assumes the constants header is compiled alongside.
*/
package eag_pkg;

    typedef enum logic [1:0] {
        EAG_MODE_REG = 2'b00,
        EAG_MODE_IMM = 2'b01,
        EAG_MODE_MEM = 2'b10,
        EAG_MODE_BAD = 2'b11
    } eag_mode_t;

    typedef enum logic [2:0] {
        EAG_REF_FETCH  = 3'b000,
        EAG_REF_PUSH   = 3'b001,
        EAG_REF_POP    = 3'b010,
        EAG_REF_STRDST = 3'b011,
        EAG_REF_DATA   = 3'b100
    } eag_ref_t;

    typedef enum logic [1:0] {
        EAG_ST_IDLE  = 2'b00,
        EAG_ST_CALC  = 2'b01,
        EAG_ST_EXTRA = 2'b10
    } eag_state_t;

    typedef struct packed {
        logic [4:0] pad;
        logic       op_pfx;
        logic       ad_pfx;
        eag_mode_t  mode;
        eag_ref_t   kind;
        logic       ovr_en;
        logic [2:0] ovr_seg;
        logic       base_en;
        logic [2:0] base_sel;
        logic       idx_en;
        logic [2:0] idx_sel;
        logic [1:0] scale;
        logic [1:0] disp_sz;
        logic       wide;
        logic [2:0] reg_sel;
    } eag_insn_t;

    typedef struct packed {
        logic [31:0] offset;
        logic [31:0] linear;
        logic [31:0] operand;
        logic [2:0]  seg;
        logic        gp_fault;
        logic        bad_form;
        logic        op32;
        logic        addr32;
    } eag_result_t;

    typedef struct packed {
        logic [22:0] pad;
        logic        busy;
        logic        done;
        logic        gp_fault;
        logic        bad_form;
        logic        addr32;
        logic        op32;
        logic [2:0]  seg;
    } eag_status_t;

endpackage

// >>> eag_reg_read.sv
/*
 Register operand read: picks one general register at byte, word or
 dword width.
 Assumes the register file arrives flattened, register 0 lowest.
*/
`timescale 1ns/1ns
`include "eag_consts.svh"

module eag_reg_read #(
    parameter int NUM_GPR = 8
) (
    // Register file
    input  wire logic [NUM_GPR*32-1:0] gpr_flat,
    // Selection
    input  wire logic [2:0]            sel,
    input  wire logic                  wide,
    input  wire logic                  op32,
    // Result
    output logic      [31:0]           value
);
    import eag_pkg::*;

    logic [31:0] full_word;
    logic [31:0] byte_src;
    logic [7:0]  byte_val;

    assign full_word = gpr_flat[sel*32 +: 32];
    assign byte_src  = gpr_flat[{1'b0, sel[1:0]}*32 +: 32];
    assign byte_val  = sel[2] ? byte_src[15:8] : byte_src[7:0];
    assign value     = !wide ? {24'h0, byte_val} :
                       op32  ? full_word : {16'h0, full_word[15:0]};

endmodule

// >>> eag_seg_pick.sv
/*
 Segment choice for one memory reference from its kind, its base
 register and any override prefix.
 Assumes the override code names one of the six segment registers.
*/
`timescale 1ns/1ns
`include "eag_consts.svh"

module eag_seg_pick (
    // Reference description
    input  wire eag_pkg::eag_ref_t kind,
    input  wire logic              ovr_en,
    input  wire logic [2:0]        ovr_seg,
    input  wire logic              base_en,
    input  wire logic [2:0]        base_sel,
    // Choice
    output logic      [2:0]        seg,
    output logic                   bad_kind
);
    import eag_pkg::*;

    logic       stack_base;
    logic [2:0] data_default;

    assign stack_base   = base_en & ((base_sel == `EAG_GPR_SP) |
                                     (base_sel == `EAG_GPR_FP));
    assign data_default = stack_base ? `EAG_SEG_STACK : `EAG_SEG_DATA;

    always_comb begin
        bad_kind = 1'b0;
        seg      = `EAG_SEG_DATA;
        unique case (kind)
            EAG_REF_FETCH:  seg = `EAG_SEG_CODE;  // [RL14]
            EAG_REF_PUSH:   seg = `EAG_SEG_STACK; // [RL14]
            EAG_REF_POP:    seg = `EAG_SEG_STACK; // [RL15]
            EAG_REF_STRDST: seg = `EAG_SEG_EXTRA; // [RL16]
            EAG_REF_DATA:   seg = ovr_en ? ovr_seg : data_default; // [RL17]
            default:        bad_kind = 1'b1;
        endcase
    end

endmodule

// >>> eag_checker.sv
/* Port assertions of the address generator.
 Assumes a bind to eag_top, one clock, synchronous high reset. */
`timescale 1ns/1ns
`include "eag_consts.svh"
module eag_checker #(parameter int APB_AW = 8) (
    input wire logic              CLK, RST, PSEL, PENABLE, PWRITE,
    input wire logic [APB_AW-1:0] PADDR,
    input wire logic [31:0]       PWDATA, OFFSET,
    input wire logic [2:0]        SEG_SEL,
    input wire logic              PREADY, PSLVERR, GP_FAULT, FORM_ERR,
    input wire logic              ADDR_SIZE32, RES_VALID
);
    default clocking @(posedge CLK); endclocking
    default disable iff (RST);
    wire logic go = PSEL && PENABLE && PREADY && PWRITE && !PSLVERR
        && PADDR == `EAG_OFF_INSN;
    wire logic both = PWDATA[15] && PWDATA[11];
    a_plain_latency: assert property (go && !both |-> ##2 RES_VALID)
        else $error("result late");
    a_both_latency: assert property (go |=>
        !RES_VALID ##[1:2] RES_VALID) else $error("result timing");
    a_gp_cause: assert property (RES_VALID && GP_FAULT |->
        OFFSET > `EAG_REAL_LIMIT && !FORM_ERR && ADDR_SIZE32)
        else $error("fault without cause");
    a_cut_16: assert property (RES_VALID && !ADDR_SIZE32 |->
        OFFSET[31:16] == 16'h0000) else $error("offset not cut");
    a_seg_code: assert property (RES_VALID |->
        SEG_SEL <= `EAG_SEG_LAST) else $error("segment code");
    a_result_hold: assert property (!RES_VALID |->
        $stable(OFFSET) && $stable(SEG_SEL)) else $error("result moved");
    a_valid_pulse: assert property (RES_VALID |=> !RES_VALID)
        else $error("valid too long");
    a_ready_wait: assert property (PSEL && !PENABLE |=> !PREADY ##1 PREADY)
        else $error("ready timing");
    a_err_qual: assert property (PSLVERR |-> PREADY) else $error("lone error");
    cover property (RES_VALID && GP_FAULT);
    cover property (RES_VALID && FORM_ERR);
    cover property (PREADY && PSLVERR);
endmodule
bind eag_top eag_checker #(.APB_AW(APB_AW)) chk_i (.CLK, .RST, .PSEL,
    .PENABLE, .PWRITE, .PADDR, .PWDATA, .OFFSET, .SEG_SEL, .PREADY,
    .PSLVERR, .GP_FAULT, .FORM_ERR, .ADDR_SIZE32, .RES_VALID);

// >>> eag_seg_model.sv
/* Segmentation unit stand-in: counts results it takes.
 Assumes results are qualified by a one-cycle valid pulse. */
`timescale 1ns/1ns
module eag_seg_model (
    input wire logic       clk, rst, res_valid,
    output logic     [7:0] results
);
    always_ff @(posedge clk) begin
        if (rst)
            results <= 8'h00;
        else if (res_valid)
            results <= results + 8'h01;
    end
endmodule

// >>> test_effective_address_generator.sv
/* Self-checking bench: APB tasks and operand scenarios.
 Assumes package, header, checker and partner model compiled first. */
`timescale 1ns/1ns
`include "eag_consts.svh"
module test_effective_address_generator;
    logic CLK = 1'b0, RST = 1'b1, PSEL = 1'b0, PENABLE = 1'b0, PWRITE = 1'b0;
    logic [7:0]  PADDR = 8'h00, nres;
    logic [31:0] PWDATA = 32'h0, PRDATA, OFFSET, LINEAR, OPERAND, q;
    logic [2:0]  SEG_SEL;
    logic PREADY, PSLVERR, GP_FAULT, FORM_ERR, OP_SIZE32, ADDR_SIZE32;
    logic RES_VALID, serr;
    logic [2:0] kd[4] = '{3'h0, 3'h1, 3'h3, 3'h4};
    logic [2:0] sx[4] = '{3'h1, 3'h2, 3'h0, 3'h5};
    int err_count = 0, checked = 0, lat;
    eag_top dut (.CLK, .RST, .PSEL, .PENABLE, .PWRITE, .PADDR, .PWDATA,
        .PRDATA, .PREADY, .PSLVERR, .OFFSET, .LINEAR, .OPERAND, .SEG_SEL,
        .GP_FAULT, .FORM_ERR, .OP_SIZE32, .ADDR_SIZE32, .RES_VALID);
    eag_seg_model far (.clk(CLK), .rst(RST), .res_valid(RES_VALID),
        .results(nres));
    task automatic apb(input logic w, logic [7:0] a, logic [31:0] d);
        @(posedge CLK);
        PSEL <= 1'b1;
        PENABLE <= 1'b0;
        PWRITE <= w;
        PADDR <= a;
        PWDATA <= d;
        @(posedge CLK);
        PENABLE <= 1'b1;
        do @(posedge CLK);
        while (PREADY !== 1'b1);
        q = PRDATA;
        serr = PSLVERR;
        PSEL <= 1'b0;
        PENABLE <= 1'b0;
    endtask
    task automatic chk(input string nm, input logic [31:0] e, g);
        checked++;
        if (g !== e) begin
            err_count++;
            $display("BAD %s exp %h got %h", nm, e, g);
        end
    endtask
    task automatic calc(input logic [31:0] ins, dsp, input int el);
        apb(1'b1, `EAG_OFF_DISP, dsp);
        apb(1'b1, `EAG_OFF_INSN, ins);
        lat = 0;
        do begin
            @(posedge CLK);
            lat++;
        end while (RES_VALID !== 1'b1 && lat < 9);
        chk("latency", el, lat);
    endtask
    task automatic give_verdict;
        $display("checks %0d errors %0d", checked, err_count);
        if (err_count == 0 && checked > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    initial forever #4 CLK = ~CLK;
    initial begin
        #24000;
        err_count++;
        give_verdict;
    end
    initial begin
        repeat (12) @(posedge CLK);
        RST <= 1'b0;
        apb(1'b0, `EAG_OFF_CFG, 32'h0);
        chk("cfg", 32'h1, q);
        apb(1'b0, 8'h1C, 32'h0);
        chk("unmapped", 32'h1, {31'h0, serr});
        apb(1'b1, 8'h20, 32'h1234_5678);
        apb(1'b1, 8'h2C, 32'h0000_1000);
        apb(1'b1, 8'h34, 32'h0000_2000);
        apb(1'b1, 8'h38, 32'h0000_0010);
        apb(1'b1, 8'h4C, 32'h0000_1234);
        apb(1'b1, 8'h48, 32'h0000_0100);
        calc(32'h0140_BE10, 32'h0000_0080, 3);
        chk("off", 32'h0000_0F90, OFFSET);
        chk("lin", 32'h0001_32D0, LINEAR);
        calc(32'h0140_D020, 32'h0000_FFF0, 2);
        chk("off", 32'h0000_1FF0, OFFSET);
        chk("seg", 32'h2, SEG_SEL);
        chk("size", 32'h0, {OP_SIZE32, ADDR_SIZE32});
        calc(32'h0340_B020, 32'h0001_0000, 2);
        chk("gp", 32'h3, {GP_FAULT, ADDR_SIZE32});
        calc(32'h0000_0004, 32'h0, 2);
        chk("byte", 32'h56, OPERAND);
        apb(1'b1, `EAG_OFF_CFG, 32'h2);
        calc(32'h0128_0ED0, 32'h4, 2);
        chk("off", 32'h84, OFFSET);
        chk("size", 32'h3, {OP_SIZE32, ADDR_SIZE32});
        chk("seg", 32'h2, SEG_SEL);
        calc(32'h0140_0C10, 32'h0, 2);
        chk("form", 32'h1, FORM_ERR);
        calc(32'h0140_0000, 32'h0, 2);
        chk("form", 32'h1, FORM_ERR);
        calc(32'h0080_0008, 32'hDEAD_BEEF, 2);
        chk("imm", 32'hDEAD_BEEF, OPERAND);
        calc(32'h0480_0008, 32'hDEAD_BEEF, 2);
        chk("imm16", 32'h0000_BEEF, OPERAND);
        for (int k = 0; k < 4; k++) begin
            calc(32'h010D_B000 | {9'h0, kd[k], 20'h0}, 32'h0, 2);
            chk("seg", {29'h0, sx[k]}, SEG_SEL);
        end
        apb(1'b1, `EAG_OFF_RESULT, 32'hFFFF_FFFF);
        apb(1'b0, `EAG_OFF_RESULT, 32'h0);
        chk("ro", 32'h0000_1000, q);
        chk("taken", 32'h0D, {24'h0, nres});
        give_verdict;
    end
endmodule
